//--- hw/dmafa_channel.sv
// One transfer channel in full address mode: registers, counters, address stepping.
// Assumes a bus agent that takes xfer_req_o and answers with a one-cycle xfer_done_i.
//
// Behaviour
// - Normal mode ignores the block counter register entirely.
// - Block mode: low byte counts down block size, high byte keeps it.
// - Low byte decrements each unit; reloads from high byte on zero.
// - Block counter drops by one per block; zero ends the transfer.
// - Control register clears to zero on reset and on standby.
// - Bit 15 selects byte (0) or word (1) units.
// - Bits 14/13 fix, increment or decrement the source address.
// - Stepping adds or removes 1 for bytes, 2 for words.
// - Bits 6/5 fix, increment or decrement the destination address.
// - Bit 11 selects block mode; bit 12 picks which side is block area.
// - Bits 10..7 and 4 store and read back with no effect.
// - Normal mode decodes pin edge, pin low, auto steal, auto burst.
// - Block mode decodes converter, pin, serial and timer sources.
// - Block mode edge request is sensed as low level first time.
// - Shared source is served by the highest-priority channel first.
// - First address register is source, second is destination.
// - Normal mode: 16-bit counter decrements per transfer; zero ends it.
// - Requests accepted only with transfer and master enables set.
//
// Design decisions made here: the register offsets and the plain strobed port.
module dmafa_channel
    import dmafa_pkg::*;
(
    input  wire logic                clk_i,          // System clock, 100 MHz
    input  wire logic                arst_n_i,       // Asynchronous reset, active low
    input  wire logic                standby_i,      // Standby entry, clears control
    input  wire logic [3:0]          addr_i,         // Register word index
    input  wire logic [31:0]         wr_data_i,      // Register write data
    input  wire logic                wr_i,           // Write strobe
    input  wire logic                rd_i,           // Read strobe
    output logic      [31:0]         rd_data_o,      // Read data, cycle after strobe
    input  wire logic                transfer_request_pin_n_i, // Request pin, active low
    input  wire logic [PERIPH_W-1:0] periph_evt_i,   // Converter, serial, timer events
    input  wire logic                prio_hold_i,    // Higher channel claims the source
    input  wire logic                xfer_done_i,    // Bus agent finished one unit
    output logic                     xfer_req_o,     // Unit transfer request
    output logic      [ADDR_W-1:0]   xfer_src_o,     // Source address of the unit
    output logic      [ADDR_W-1:0]   xfer_dst_o,     // Destination address of the unit
    output logic                     xfer_word_o,    // Unit is a word
    output logic                     xfer_burst_o,   // Burst request selected
    output logic                     block_end_o,    // One block finished, pulse
    output logic                     transfer_end_o  // Whole transfer finished, pulse
);
    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        dmafa_state_e      state;
        logic [ADDR_W-1:0] src;          // source_address
        logic [ADDR_W-1:0] dst;          // destination_address
        logic [ADDR_W-1:0] area_start;   // Block area start for reload
        logic [15:0]       size_count;   // block_size_count
        logic [15:0]       blk_count;    // block_count
        logic [15:0]       ctrl;         // channel_control
        logic              te;           // channel_transfer_enable
        logic              me;           // channel_master_enable
        logic              first;        // First unit since enable
        logic [2:0]        pin_sync;     // Pin synchroniser
        logic              pin_lvl;      // Filtered pin level
        logic              pin_fall;     // Falling edge seen, pending
        logic [31:0]       rd_data;
        logic              req;
        logic              blk_end;
        logic              xfer_end;
    } dmafa_chan_s;

    dmafa_chan_s r;
    dmafa_chan_s next_r;

    dmafa_act_if act ();

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Address step, shared by both sides
    function automatic logic [ADDR_W-1:0] dmafa_step(input logic [ADDR_W-1:0] a,
                                                     input logic en, input logic dec,
                                                     input logic word);
        logic [ADDR_W-1:0] inc;
        inc = word ? ADDR_W'(2) : ADDR_W'(1);
        if (!en) begin
            dmafa_step = a;
        end else if (dec) begin
            dmafa_step = a - inc;
        end else begin
            dmafa_step = a + inc;
        end
    endfunction : dmafa_step

    logic blk_mode;
    logic word_sel;
    logic enabled;
    assign blk_mode = r.ctrl[BIT_BLOCK_MODE_ENABLE];
    assign word_sel = r.ctrl[BIT_TRANSFER_SIZE_SEL];
    assign enabled  = r.te && r.me;

    // ****************************************************************
    // Activation decoder
    // ****************************************************************
    assign act.sel      = r.ctrl[BIT_ACT_SEL_HI:0];
    assign act.blk      = blk_mode;
    assign act.first    = r.first;
    assign act.pin_fall = r.pin_fall;
    assign act.pin_low  = !r.pin_lvl;
    assign act.periph   = periph_evt_i;

    dmafa_act_decode u_decode (
        .act (act.dec)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [ADDR_W-1:0] ns;
        logic [ADDR_W-1:0] nd;
        logic [7:0]        low;
        ns     = '0;
        nd     = '0;
        low    = '0;
        next_r = r;
        next_r.blk_end  = 1'b0;
        next_r.xfer_end = 1'b0;

        // Pin filter: change counts once stages two and three agree
        next_r.pin_sync = {r.pin_sync[1:0], transfer_request_pin_n_i};
        if (r.pin_sync[1] == r.pin_sync[2]) begin
            next_r.pin_lvl = r.pin_sync[2];
            if (r.pin_lvl && !r.pin_sync[2]) begin
                next_r.pin_fall = 1'b1;
            end
        end

        // Transfer sequencing
        unique case (r.state)
            DMAFA_IDLE: begin
                if (enabled && act.start && !prio_hold_i) begin
                    next_r.state = DMAFA_MOVE;
                    next_r.req   = 1'b1;
                    next_r.pin_fall = next_r.pin_fall && !r.pin_fall; // Consumed; an edge arriving in the same cycle is dropped
                end
            end
            DMAFA_MOVE: begin
                if (xfer_done_i) begin
                    next_r.req   = 1'b0;
                    next_r.state = DMAFA_IDLE;
                    next_r.first = 1'b0;
                    // Step both sides before any further unit
                    ns = dmafa_step(r.src, r.ctrl[BIT_SOURCE_STEP_ENABLE],
                                    r.ctrl[BIT_SOURCE_STEP_DIR], word_sel);
                    nd = dmafa_step(r.dst, r.ctrl[BIT_DEST_STEP_ENABLE],
                                    r.ctrl[BIT_DEST_STEP_DIR], word_sel);
                    next_r.src = ns;
                    next_r.dst = nd;
                    if (!blk_mode) begin
                        // Block counter untouched here
                        next_r.size_count = r.size_count - 16'h0001;
                        if (r.size_count == 16'h0001) begin
                            next_r.te       = 1'b0;
                            next_r.xfer_end = 1'b1;
                        end
                    end else begin
                        low = r.size_count[7:0] - 8'h01;
                        next_r.size_count[7:0] = low;
                        if (low == 8'h00) begin
                            next_r.size_count[7:0] = r.size_count[15:8];
                            next_r.blk_count = r.blk_count - 16'h0001;
                            next_r.blk_end   = 1'b1;
                            // Block area restarts, other side runs on
                            if (r.ctrl[BIT_BLOCK_AREA_SIDE]) begin
                                next_r.src = r.area_start;
                            end else begin
                                next_r.dst = r.area_start;
                            end
                            if (r.blk_count == 16'h0001) begin
                                next_r.te       = 1'b0;
                                next_r.xfer_end = 1'b1;
                            end
                        end
                    end
                end
            end
        endcase

        // Register writes; a write lands after the hardware update
        if (wr_i) begin
            unique case (addr_i)
                OFS_SOURCE_ADDRESS: begin
                    next_r.src = wr_data_i[ADDR_W-1:0];
                    if (r.ctrl[BIT_BLOCK_AREA_SIDE]) begin
                        next_r.area_start = wr_data_i[ADDR_W-1:0];
                    end
                end
                OFS_DEST_ADDRESS: begin
                    next_r.dst = wr_data_i[ADDR_W-1:0];
                    if (!r.ctrl[BIT_BLOCK_AREA_SIDE]) begin
                        next_r.area_start = wr_data_i[ADDR_W-1:0];
                    end
                end
                OFS_BLOCK_SIZE_COUNT: next_r.size_count = wr_data_i[15:0];
                OFS_BLOCK_COUNT:      next_r.blk_count  = wr_data_i[15:0];
                OFS_CHANNEL_CONTROL:  next_r.ctrl       = wr_data_i[15:0];
                OFS_CHANNEL_ENABLE: begin
                    next_r.te = wr_data_i[BIT_TRANSFER_ENABLE];
                    next_r.me = wr_data_i[BIT_MASTER_ENABLE];
                    // Off-to-on arms the first-transfer level sense
                    if (!enabled && wr_data_i[BIT_TRANSFER_ENABLE] && wr_data_i[BIT_MASTER_ENABLE]) begin
                        next_r.first    = 1'b1;
                        next_r.pin_fall = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Standby wipes the control register only
        if (standby_i) begin
            next_r.ctrl = CONTROL_RESET;
        end

        // Read data stand one cycle, zero otherwise and when unmapped
        next_r.rd_data = '0;
        if (rd_i) begin
            unique case (addr_i)
                OFS_SOURCE_ADDRESS:   next_r.rd_data = {8'h00, r.src};
                OFS_DEST_ADDRESS:     next_r.rd_data = {8'h00, r.dst};
                OFS_BLOCK_SIZE_COUNT: next_r.rd_data = {16'h0000, r.size_count};
                OFS_BLOCK_COUNT:      next_r.rd_data = {16'h0000, r.blk_count};
                OFS_CHANNEL_CONTROL:  next_r.rd_data = {16'h0000, r.ctrl};
                OFS_CHANNEL_ENABLE:   next_r.rd_data = {30'h0, r.me, r.te};
                OFS_CHANNEL_STATUS:   next_r.rd_data = {29'h0, r.first, r.pin_lvl, r.req};
                default:              next_r.rd_data = '0;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Counters and addresses have no documented reset, zero is chosen
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r          <= '0;
            r.ctrl     <= CONTROL_RESET;
            r.pin_sync <= 3'b111;
            r.pin_lvl  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ****************************************************************
    // Outputs, all straight from flip-flops except the decoded xfer_burst_o
    // ****************************************************************
    assign rd_data_o      = r.rd_data;
    assign xfer_req_o     = r.req;
    assign xfer_src_o     = r.src;
    assign xfer_dst_o     = r.dst;
    assign xfer_word_o    = r.ctrl[BIT_TRANSFER_SIZE_SEL];
    assign xfer_burst_o   = r.ctrl[BIT_ACT_SEL_HI:0] == ACT_AUTO_BURST && !r.ctrl[BIT_BLOCK_MODE_ENABLE];
    assign block_end_o    = r.blk_end;
    assign transfer_end_o = r.xfer_end;
endmodule : dmafa_channel

//--- hw/dmafa_pkg.sv
// Constants for the full address transfer channel control block.
// Assumes a single 100 MHz clock and a plain word-indexed register port.
package dmafa_pkg;
    // ****************************************************************
    // Register indices (word addresses on the register port)
    // ****************************************************************
    localparam logic [3:0] OFS_SOURCE_ADDRESS   = 4'h0;
    localparam logic [3:0] OFS_DEST_ADDRESS     = 4'h1;
    localparam logic [3:0] OFS_BLOCK_SIZE_COUNT = 4'h2;
    localparam logic [3:0] OFS_BLOCK_COUNT      = 4'h3;
    localparam logic [3:0] OFS_CHANNEL_CONTROL  = 4'h4;
    localparam logic [3:0] OFS_CHANNEL_ENABLE   = 4'h5;
    localparam logic [3:0] OFS_CHANNEL_STATUS   = 4'h6;

    // ****************************************************************
    // Field positions of channel_control
    // ****************************************************************
    localparam int BIT_TRANSFER_SIZE_SEL   = 15;
    localparam int BIT_SOURCE_STEP_DIR     = 14;
    localparam int BIT_SOURCE_STEP_ENABLE  = 13;
    localparam int BIT_BLOCK_AREA_SIDE     = 12;
    localparam int BIT_BLOCK_MODE_ENABLE   = 11;
    localparam int BIT_DEST_STEP_DIR       = 6;
    localparam int BIT_DEST_STEP_ENABLE    = 5;
    localparam int BIT_ACT_SEL_HI          = 3;

    // Fields of the enable register
    localparam int BIT_TRANSFER_ENABLE     = 0;
    localparam int BIT_MASTER_ENABLE       = 1;

    // ****************************************************************
    // Reset values and widths
    // ****************************************************************
    localparam logic [15:0] CONTROL_RESET  = 16'h0000;
    localparam int          ADDR_W         = 24;
    localparam int          PERIPH_W       = 11;

    // Activation source codes
    localparam logic [3:0] ACT_ADC_END      = 4'h1;
    localparam logic [3:0] ACT_PIN_EDGE     = 4'h2;
    localparam logic [3:0] ACT_PIN_LOW      = 4'h3;
    localparam logic [3:0] ACT_AUTO_STEAL   = 4'h6;
    localparam logic [3:0] ACT_AUTO_BURST   = 4'h7;
    localparam logic [3:0] ACT_SERIAL_FIRST = 4'h4;
    localparam logic [3:0] ACT_TIMER_FIRST  = 4'h8;
    localparam logic [3:0] ACT_TIMER_LAST   = 4'hD;

    // Channel sequencer states
    typedef enum logic [0:0] {
        DMAFA_IDLE = 1'b0,
        DMAFA_MOVE = 1'b1
    } dmafa_state_e;
endpackage : dmafa_pkg

//--- hw/dmafa_act_if.sv
// Carrier between the channel and its activation source decoder.
// Assumes both ends sit on the same clock.
interface dmafa_act_if;
    logic [3:0]                   sel;       // Activation source code
    logic                         blk;       // Block mode selected
    logic                         first;     // First transfer since enable
    logic                         pin_fall;  // Filtered pin falling edge
    logic                         pin_low;   // Filtered pin low level
    logic [dmafa_pkg::PERIPH_W-1:0] periph;  // Peripheral event levels
    logic                         start;     // Source asks for a transfer

    modport chan (output sel, output blk, output first, output pin_fall, output pin_low,
                  output periph, input start);
    modport dec  (input sel, input blk, input first, input pin_fall, input pin_low,
                  input periph, output start);
endinterface : dmafa_act_if

//--- hw/dmafa_act_decode.sv
// Activation source decoder for one paired channel.
// Assumes all inputs are already on the channel clock.
module dmafa_act_decode
    import dmafa_pkg::*;
(
    dmafa_act_if.dec act  // Decoder side of the carrier
);
    // ****************************************************************
    // Source selection
    // ****************************************************************
    // Pure decode; the channel registers whatever depends on it
    always_comb begin
        act.start = 1'b0;
        if (!act.blk) begin
            unique case (act.sel)
                ACT_PIN_EDGE:   act.start = act.pin_fall;
                ACT_PIN_LOW:    act.start = act.pin_low;
                ACT_AUTO_STEAL: act.start = 1'b1;
                ACT_AUTO_BURST: act.start = 1'b1;
                default:        act.start = 1'b0;
            endcase
        end else begin
            if (act.sel == ACT_ADC_END) begin
                act.start = act.periph[0];
            end else if (act.sel == ACT_PIN_EDGE) begin
                // Edge falls back to level on the first transfer
                act.start = act.first ? act.pin_low : act.pin_fall;
            end else if (act.sel == ACT_PIN_LOW) begin
                act.start = act.pin_low;
            end else if (act.sel >= ACT_SERIAL_FIRST && act.sel <= ACT_TIMER_LAST) begin
                act.start = act.periph[act.sel - 4'h3];
            end else begin
                act.start = 1'b0;
            end
        end
    end
endmodule : dmafa_act_decode

//--- sim/dmafa_asserts.sv
// Checker for the transfer channel: register port and unit handshake.
// Assumes it is bound to dmafa_channel and sees only that module's ports.
module dmafa_asserts
    import dmafa_pkg::*;
(
    input wire logic              clk_i,          // Clock
    input wire logic              arst_n_i,       // Reset, active low
    input wire logic              standby_i,      // Standby entry
    input wire logic [3:0]        addr_i,         // Register index
    input wire logic              wr_i,           // Write strobe
    input wire logic              rd_i,           // Read strobe
    input wire logic [31:0]       rd_data_o,      // Read data
    input wire logic              xfer_done_i,    // Unit done
    input wire logic              xfer_req_o,     // Unit request
    input wire logic [ADDR_W-1:0] xfer_src_o,     // Source address
    input wire logic [ADDR_W-1:0] xfer_dst_o,     // Destination address
    input wire logic              xfer_word_o,    // Word unit
    input wire logic              block_end_o,    // Block end pulse
    input wire logic              transfer_end_o  // Transfer end pulse
);
    // ****************************************************************
    // Steps of one unit transfer
    // ****************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    sequence s_wait;
        xfer_req_o && !xfer_done_i;
    endsequence
    sequence s_unit;
        xfer_req_o && xfer_done_i;
    endsequence
    // Request holds until done and drops after it; addresses and size must not move while a unit is in flight unless a write (or standby, for size) lands
    AST_REQ_HOLD: assert property (s_wait |=> xfer_req_o) else $error("request dropped early");
    AST_REQ_DROP: assert property (s_unit |=> !xfer_req_o) else $error("request kept after done");
    AST_SRC_HOLD: assert property (s_wait ##0 !wr_i |=> $stable(xfer_src_o)) else $error("source moved");
    AST_DST_HOLD: assert property (s_wait ##0 !wr_i |=> $stable(xfer_dst_o)) else $error("dest moved");
    AST_WORD_HOLD: assert property (s_wait ##0 !wr_i && !standby_i |=> $stable(xfer_word_o))
        else $error("unit size moved");
    // End pulses follow a finished unit and stand one cycle
    AST_END_CAUSE: assert property (transfer_end_o |-> $past(xfer_req_o && xfer_done_i))
        else $error("end without unit");
    AST_BLK_CAUSE: assert property (block_end_o |-> $past(xfer_req_o && xfer_done_i))
        else $error("block end without unit");
    AST_END_STOP: assert property (transfer_end_o && !wr_i |=> !transfer_end_o && !xfer_req_o)
        else $error("channel ran on after end");
    // Register port readback properties
    AST_ADDR_HI: assert property (rd_i && addr_i == OFS_SOURCE_ADDRESS |=> rd_data_o[31:24] == 8'h00)
        else $error("address upper byte set");
    AST_STANDBY: assert property (standby_i ##1 rd_i && addr_i == OFS_CHANNEL_CONTROL |=> rd_data_o == 32'h0)
        else $error("control kept in standby");
endmodule : dmafa_asserts

bind dmafa_channel dmafa_asserts chk_u (.*);

//--- sim/dmafa_bus_agent.sv
// Bus agent model: finishes each requested unit after a set latency.
// Assumes the channel holds its request until the cycle after done.
module dmafa_bus_agent (
    input  wire logic       clk_i,      // System clock
    input  wire logic       arst_n_i,   // Reset, active low
    input  wire logic [3:0] lat_i,      // Extra wait cycles per unit
    input  wire logic       xfer_req_i, // Unit request from channel
    output logic            xfer_done_o // One-cycle unit done
);
    logic [3:0] cnt;
    // Done is one cycle; never repeated while the request falls
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 4'h0;
            xfer_done_o <= 1'b0;
        end else if (xfer_done_o) begin
            xfer_done_o <= 1'b0;
        end else if (xfer_req_i) begin
            xfer_done_o <= (cnt >= lat_i);
            cnt <= (cnt >= lat_i) ? 4'h0 : cnt + 4'h1;
        end
    end
endmodule : dmafa_bus_agent

//--- sim/tb.sv
// Self-checking bench for the full address transfer channel.
// Assumes the bus agent model and the bound checker are compiled alongside.
module tb
    import dmafa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk_i = 1'b0, arst_n_i = 1'b0, standby_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
    logic                pin_n = 1'b1, prio_hold_i = 1'b0, xfer_done_i, xfer_req_o, word, burst, blk_end, end_p;
    logic [3:0]          addr_i = 4'h0, lat = 4'h0;
    logic [31:0]         wr_data_i = 32'h0, rd_data_o, v;
    logic [PERIPH_W-1:0] evt = '0;
    logic [ADDR_W-1:0]   src, dst;
    int                  bad_count = 0, compares = 0;
    dmafa_channel dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .standby_i(standby_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .transfer_request_pin_n_i(pin_n),
        .periph_evt_i(evt), .prio_hold_i(prio_hold_i), .xfer_done_i(xfer_done_i), .xfer_req_o(xfer_req_o),
        .xfer_src_o(src), .xfer_dst_o(dst), .xfer_word_o(word), .xfer_burst_o(burst),
        .block_end_o(blk_end), .transfer_end_o(end_p));
    dmafa_bus_agent agent_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .lat_i(lat), .xfer_req_i(xfer_req_o),
        .xfer_done_o(xfer_done_i));
    // ****************************************************************
    // Bus cycles and comparison
    // ****************************************************************
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask : chk
    // Read data is taken only in the cycle after the strobe
    task automatic rdchk(input string n, input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(n, e, rd_data_o & m);
    endtask : rdchk
    // Request seen within n cycles; covers the pin filter delay
    task automatic watch(input int n, output logic seen);
        seen = 1'b0;
        repeat (n) @(negedge clk_i) if (xfer_req_o === 1'b1) seen = 1'b1;
    endtask : watch
    task automatic conclude();
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_regs();
        rdchk("ctrl reset", OFS_CHANNEL_CONTROL, 32'h0, 32'hFFFF);
        wr(OFS_CHANNEL_CONTROL, 32'h0790);
        rdchk("reserved bits", OFS_CHANNEL_CONTROL, 32'h0790, 32'hFFFF);
        @(posedge clk_i) standby_i <= 1'b1;
        @(posedge clk_i) standby_i <= 1'b0;
        rdchk("ctrl standby", OFS_CHANNEL_CONTROL, 32'h0, 32'hFFFF);
        rdchk("unmapped", 4'hF, 32'h0, 32'hFFFFFFFF);
        wr(OFS_SOURCE_ADDRESS, 32'hFFFFFFFF);
        rdchk("addr width", OFS_SOURCE_ADDRESS, 32'h00FFFFFF, 32'hFFFFFFFF);
    endtask : t_regs
    // Whole transfers in both modes, then counters and addresses
    task automatic t_xfer();
        logic [15:0] ctl [6] = '{16'h2006, 16'hE027, 16'h0063, 16'h2821, 16'h3821, 16'h0802};
        logic [15:0] ca [6] = '{16'h0003, 16'h0002, 16'h0002, 16'h0202, 16'h0202, 16'h0101};
        logic [15:0] cbv [6] = '{16'h0005, 16'h0000, 16'h0000, 16'h0002, 16'h0002, 16'h0001};
        logic [31:0] es [6] = '{32'h103, 32'h0FC, 32'h100, 32'h104, 32'h100, 32'h100};
        logic [31:0] ed [6] = '{32'h200, 32'h204, 32'h1FE, 32'h200, 32'h204, 32'h200};
        int u [6] = '{3, 2, 2, 4, 4, 1};
        int nu, nb;
        for (int i = 0; i < 6; i++) begin
            lat <= 4'(i % 4);
            pin_n <= ~(ctl[i][1:0] == 2'b11 || ctl[i][3:0] == 4'h2);
            evt <= 11'h001;
            wr(OFS_CHANNEL_CONTROL, {16'h0, ctl[i]});
            wr(OFS_SOURCE_ADDRESS, 32'h100);
            wr(OFS_DEST_ADDRESS, 32'h200);
            wr(OFS_BLOCK_SIZE_COUNT, {16'h0, ca[i]});
            wr(OFS_BLOCK_COUNT, {16'h0, cbv[i]});
            wr(OFS_CHANNEL_ENABLE, 32'h3);
            nu = 0;
            nb = 0;
            for (int k = 0; k < 3000 && end_p !== 1'b1; k++) begin
                @(negedge clk_i);
                nu += (xfer_req_o === 1'b1 && xfer_done_i === 1'b1);
                nb += (blk_end === 1'b1);
            end
            chk("units", u[i], nu);
            chk("blocks", ctl[i][11] ? cbv[i] : 0, nb);
            chk("word", ctl[i][15], word);
            chk("burst", ctl[i][3:0] == 4'h7 && !ctl[i][11], burst);
            rdchk("src", OFS_SOURCE_ADDRESS, es[i], 32'hFFFFFFFF);
            rdchk("dst", OFS_DEST_ADDRESS, ed[i], 32'hFFFFFFFF);
            rdchk("size", OFS_BLOCK_SIZE_COUNT, ctl[i][11] ? ca[i] : 0, 32'hFFFF);
            rdchk("bcount", OFS_BLOCK_COUNT, ctl[i][11] ? 0 : cbv[i], 32'hFFFF);
            rdchk("enable", OFS_CHANNEL_ENABLE, 32'h2, 32'h3);
        end
    endtask : t_xfer
    // Every code in both modes, all sources active after enable
    task automatic t_codes();
        logic seen;
        logic ok;
        for (int m = 0; m < 32; m++) begin
            ok = m[4] ? (m[3:0] != 4'h0 && m[3:0] < 4'hE) : (m[3:0] inside {4'h2, 4'h3, 4'h6, 4'h7});
            pin_n <= 1'b1;
            evt <= 11'h7FF;
            wr(OFS_CHANNEL_CONTROL, {16'h0, 4'h0, m[4], 7'h0, m[3:0]});
            wr(OFS_BLOCK_SIZE_COUNT, 32'h0101);
            wr(OFS_BLOCK_COUNT, 32'h1);
            wr(OFS_CHANNEL_ENABLE, 32'h3);
            pin_n <= 1'b0;
            watch(16, seen);
            chk("code start", ok, seen);
            wr(OFS_CHANNEL_ENABLE, 32'h0);
        end
    endtask : t_codes
    // Both enables needed; a held source waits for the priority owner
    task automatic t_gate();
        logic seen;
        wr(OFS_CHANNEL_CONTROL, 32'h0006);
        wr(OFS_BLOCK_SIZE_COUNT, 32'h1);
        for (int e = 1; e < 3; e++) begin
            wr(OFS_CHANNEL_ENABLE, e);
            watch(10, seen);
            chk("one enable", 1'b0, seen);
        end
        prio_hold_i <= 1'b1;
        wr(OFS_CHANNEL_ENABLE, 32'h3);
        watch(10, seen);
        chk("held", 1'b0, seen);
        prio_hold_i <= 1'b0;
        watch(10, seen);
        chk("released", 1'b1, seen);
    endtask : t_gate
    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (10) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_xfer();
        t_codes();
        t_gate();
        conclude();
    end
    // Whole run needs well under ten thousand cycles
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        conclude();
    end
endmodule : tb
